// ---- common/tov_defs.svh ----
/*
 Constants of the timed output validation block: channel count,
 register selects, time mode fields, reset values and timing.
 Assumes a 20 MHz core clock and a 1 us time base.
*/
`ifndef TOV_DEFS_SVH
`define TOV_DEFS_SVH

// ----------------------------------------
// Sizes and timing
// ----------------------------------------
`define TOV_NCH        4
`define TOV_CLK_NS     50
`define TOV_US_NS      1000
`define TOV_US_CYCLES  (`TOV_US_NS / `TOV_CLK_NS)
`define TOV_PRE_W      5

// ----------------------------------------
// Link write selects
// ----------------------------------------
`define TOV_REG_VALUE  2'h0
`define TOV_REG_STAMP  2'h1
`define TOV_REG_MODE   2'h2
`define TOV_REG_ON     2'h3

// ----------------------------------------
// Time mode fields and resets
// ----------------------------------------
`define TOV_WIN_LSB    0
`define TOV_WIN_MSB    4
`define TOV_SEL_LSB    8
`define TOV_SEL_MSB    9
`define TOV_FMT_BIT    15
`define TOV_MODE_MASK  16'h831F
`define TOV_MODE_RESET(i) (16'(i) << `TOV_SEL_LSB)
`define TOV_ON_RESET   4'h0
`define TOV_RSVD_ZERO  4'h0

`endif

// ---- common/tov_pkg.sv ----
/*
 Types of the timed output validation block: link request,
 status answer and the block's complete state.
 Assumes tov_defs.svh is on the include path.
*/
`include "tov_defs.svh"

package tov_pkg;

	typedef enum logic [1:0]
	{
		TOV_WR_VALUE = `TOV_REG_VALUE,
		TOV_WR_STAMP = `TOV_REG_STAMP,
		TOV_WR_MODE  = `TOV_REG_MODE,
		TOV_WR_ON    = `TOV_REG_ON
	} tov_reg_type;

	typedef struct packed
	{
		logic        frameStart; // Link cycle start, refTime valid
		logic        startup;    // Link startup, refTime valid
		logic [31:0] refTime;    // Master or system time
		logic        wrEn;       // Cyclic register write
		tov_reg_type wrReg;
		logic [1:0]  wrChan;
		logic [31:0] wrData;
	} tov_link_type;

	typedef struct packed
	{
		logic signed [7:0] lifeCount;
		logic [7:0]        onEcho;
		logic [7:0]        present;
		logic [3:0]        led;
		logic [31:0]       sharedTime;
		logic [31:0]       stampTime;
	} tov_status_type;

	typedef struct packed
	{
		logic [`TOV_PRE_W-1:0] prescale;
		logic [31:0]           localTime;
		logic [31:0]           offset;
		logic [31:0]           shared;
		logic signed [7:0]     life;
		logic [3:0][15:0]      value;
		logic [3:0][31:0]      stamp;
		logic [3:0][15:0]      mode;
		logic [3:0]            on;
		logic [3:0]            shut;
		logic [2:0]            evSync;
		logic                  evLevel;
		logic [31:0]           capture;
		logic [3:0][15:0]      outValue;
		logic [3:0]            led;
		logic [3:0]            present;
	} tov_state_type;

endpackage

// ---- design/tov_timed_output.sv ----
/*
 Four-channel timed output validation: shared microsecond time
 aligned to the link master, per-channel timestamp shutdown,
 enable bits, status bits, life counter and event timestamping.
 Assumes the link logic runs on clk; eventPin is asynchronous.
*/
`timescale 1ns/1ps
`include "tov_defs.svh"

// Functional notes
// - A channel whose output value is zero has its LED off.
// - Signed 8-bit life counter advances on every link cycle.
// - Monitored channel shuts down once shared time reaches stamp.
// - Enable bits 0..3 switch channels 1..4; bits 4..7 zero.
// - Enable bits act only on monitored channels.
// - Enable byte is echoed back on every cyclic read.
// - Status bits show monitored channels actually driving.
// - Shared time is a 32-bit counter stepping once per us.
// - Time changes sign and wraps freely, nothing else happens.
// - Link startup loads the time from system time.
// - Each cycle start stores master time minus local time.
// - Event time is local time plus stored difference.
// - Timestamp event captures shared time on the fourth clock edge after the pin rises.
// - Device performs an I/O update every bus cycle.
// - On timeout the channel switches off and value resets.
// - Shutdown lasts until a new valid stamp arrives.
// - Mode holds window code, timer select and stamp width.
// - Mode bits 8..9 select the timer, default own channel.
module tov_timed_output
(
	input  wire logic                  clk,      // 20 MHz core clock
	input  wire logic                  arst_n,   // Async reset
	input  wire logic                  eventPin, // Timestamp event pin
	input  wire tov_pkg::tov_link_type linkIn,   // Cyclic link writes
	output tov_pkg::tov_status_type    status,   // Cyclic read data
	output logic [3:0][15:0]           outValue  // Converter values
);
	import tov_pkg::*;

	// ----------------------------------------
	// State and per-channel terms
	// ----------------------------------------
	tov_state_type st;
	tov_state_type next_st;
	logic          usTick;
	logic [3:0]    monitored;
	logic [3:0]    expired;
	logic [3:0]    stampOk;
	logic [3:0]    modeArm;
	logic [3:0]    drive;

	assign usTick = st.prescale == `TOV_PRE_W'(`TOV_US_CYCLES - 1);

	// Time left until a stamp, in the channel's own width
	function automatic logic signed [31:0] tov_left
	(
		input logic [31:0] ts,
		input logic [31:0] now,
		input logic        wide
	);
		logic [15:0] d16;
		d16 = ts[15:0] - now[15:0];
		tov_left = wide ? ts - now : {{16{d16[15]}}, d16};
	endfunction

	// ----------------------------------------
	// Per-channel validation
	// ----------------------------------------
	genvar ch;
	generate
		for (ch = 0; ch < `TOV_NCH; ch++)
		begin : g_ch
			logic [1:0]         sel;
			logic [4:0]         win;
			logic               wide;
			logic signed [31:0] leftNow;
			logic signed [31:0] leftNew;
			logic [32:0]        window;

			assign sel  = st.mode[ch][`TOV_SEL_MSB:`TOV_SEL_LSB];
			assign win  = st.mode[ch][`TOV_WIN_MSB:`TOV_WIN_LSB];
			assign wide = st.mode[ch][`TOV_FMT_BIT];
			assign window = 33'h1 << win;
			assign leftNow = tov_left(st.stamp[sel], st.shared, wide);
			assign leftNew = tov_left(linkIn.wrData, st.shared, wide);
			assign monitored[ch] = win != 5'h0;
			// Reaching the stamp exactly counts as expiry
			assign expired[ch] = monitored[ch] && !st.shut[ch]
				&& leftNow <= 32'sh0;
			// A stamp beyond the window is not accepted
			assign stampOk[ch] = linkIn.wrEn && linkIn.wrReg == TOV_WR_STAMP
				&& linkIn.wrChan == sel && leftNew > 32'sh0
				&& {1'b0, leftNew} <= window;
			assign modeArm[ch] = linkIn.wrEn && linkIn.wrReg == TOV_WR_MODE
				&& linkIn.wrChan == 2'(ch)
				&& linkIn.wrData[`TOV_WIN_MSB:`TOV_WIN_LSB] != 5'h0;
			assign drive[ch] = !monitored[ch]
				|| (st.on[ch] && !st.shut[ch]);
		end
	endgenerate

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		next_st = st;
		next_st.prescale = usTick ? '0 : st.prescale + `TOV_PRE_W'(1);
		if (usTick)
		begin
			// Free wrap through sign change and overflow
			next_st.localTime = st.localTime + 32'h1;
		end
		if (linkIn.startup)
		begin
			next_st.localTime = linkIn.refTime;
			next_st.offset    = 32'h0;
			next_st.prescale  = '0;
		end
		else if (linkIn.frameStart)
		begin
			next_st.offset = linkIn.refTime - st.localTime;
			next_st.life   = 8'(st.life + 8'sh1);
		end
		if (linkIn.wrEn)
		begin
			case (linkIn.wrReg)
				TOV_WR_VALUE:
				begin
					next_st.value[linkIn.wrChan] = linkIn.wrData[15:0];
				end
				TOV_WR_STAMP:
				begin
					next_st.stamp[linkIn.wrChan] = linkIn.wrData;
				end
				TOV_WR_MODE:
				begin
					next_st.mode[linkIn.wrChan] =
						linkIn.wrData[15:0] & `TOV_MODE_MASK;
				end
				TOV_WR_ON:
				begin
					next_st.on = linkIn.wrData[3:0];
				end
				default:
				begin
					next_st.on = st.on;
				end
			endcase
		end
		for (int i = 0; i < `TOV_NCH; i++)
		begin
			// Expiry wins over a stamp landing in the same cycle
			next_st.shut[i] = expired[i]
				|| ((st.shut[i] || modeArm[i]) && !stampOk[i]);
			if (expired[i])
			begin
				next_st.value[i] = 16'h0;
			end
			next_st.outValue[i] = drive[i] ? st.value[i] : 16'h0;
			next_st.led[i] = drive[i] && st.value[i] != 16'h0;
			next_st.present[i] = monitored[i] && drive[i];
		end
		// Only the second and third stages are compared
		next_st.evSync = {st.evSync[1:0], eventPin};
		if (st.evSync[2] == st.evSync[1])
		begin
			next_st.evLevel = st.evSync[1];
		end
		if (next_st.evLevel && !st.evLevel)
		begin
			next_st.capture = st.shared;
		end
		next_st.shared = next_st.localTime + next_st.offset;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st <= '0;
			for (int i = 0; i < `TOV_NCH; i++)
			begin
				st.mode[i] <= `TOV_MODE_RESET(i);
			end
		end
		else
		begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign outValue          = st.outValue;
	assign status.lifeCount  = st.life;
	assign status.onEcho     = {`TOV_RSVD_ZERO, st.on};
	assign status.present    = {`TOV_RSVD_ZERO, st.present};
	assign status.led        = st.led;
	assign status.sharedTime = st.shared;
	assign status.stampTime  = st.capture;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	AST_LIFE_STEP: assert property
		(linkIn.frameStart && !linkIn.startup |=>
			status.lifeCount == 8'($past(st.life) + 8'sh1))
		else $error("life counter did not advance");

	AST_TIME_STEP: assert property
		(usTick && !linkIn.startup |=>
			st.localTime == 32'($past(st.localTime) + 32'h1))
		else $error("local time did not step");

	AST_TICK_GAP: assert property
		(usTick |=> !usTick [*8])
		else $error("microsecond tick too frequent");

	AST_START_INIT: assert property
		(linkIn.startup |=>
			st.localTime == $past(linkIn.refTime) && st.offset == 32'h0)
		else $error("startup did not load time");

	AST_OFFSET: assert property
		(linkIn.frameStart && !linkIn.startup |=>
			st.offset == 32'($past(linkIn.refTime) - $past(st.localTime))
			##1 status.sharedTime == 32'(st.localTime + st.offset))
		else $error("time difference not stored");

	AST_CAPTURE: assert property
		(st.evLevel && !$past(st.evLevel) |->
			st.capture == $past(st.shared))
		else $error("event time not captured");

	AST_ECHO: assert property
		(linkIn.wrEn && linkIn.wrReg == TOV_WR_ON |=>
			status.onEcho == {4'h0, $past(linkIn.wrData[3:0])})
		else $error("enable echo wrong");

	AST_STAMP_STORE: assert property
		(linkIn.wrEn && linkIn.wrReg == TOV_WR_STAMP |=>
			st.stamp[$past(linkIn.wrChan)] == $past(linkIn.wrData))
		else $error("validity stamp not stored");

	generate
		for (ch = 0; ch < `TOV_NCH; ch++)
		begin : g_ast
			sequence tovShutNow;
				st.shut[ch] && st.value[ch] == 16'h0;
			endsequence
			sequence tovDark;
				outValue[ch] == 16'h0 && !status.present[ch];
			endsequence

			AST_EXPIRE: assert property
				(expired[ch] && !linkIn.wrEn |=> tovShutNow ##1 tovDark)
				else $error("expired channel not shut");

			AST_HOLD: assert property
				(st.shut[ch] && !stampOk[ch] |=> st.shut[ch])
				else $error("shutdown left without stamp");

			AST_UNMON: assert property
				(!monitored[ch] |=> outValue[ch] == $past(st.value[ch]))
				else $error("unmonitored channel not driven");

			AST_OFF_BIT: assert property
				(monitored[ch] && !st.on[ch] |=> tovDark)
				else $error("disabled channel still driving");

			AST_LED: assert property
				(st.value[ch] == 16'h0 |=> !status.led[ch])
				else $error("LED on at zero value");

			AST_STAMP_TAKE: assert property
				(st.shut[ch] && stampOk[ch] |=> !st.shut[ch])
				else $error("shutdown kept after stamp");

			AST_MODE_ARM: assert property
				(modeArm[ch] |=> st.shut[ch])
				else $error("armed channel not held off");

			AST_DRIVE: assert property
				(monitored[ch] && st.on[ch] && !st.shut[ch]
					|=> outValue[ch] == $past(st.value[ch]))
				else $error("enabled channel not driven");

			AST_UNMON_PRES: assert property
				(!monitored[ch] |=> !status.present[ch])
				else $error("unmonitored status bit set");
		end
	endgenerate

endmodule

// ---- tb/timed_output_validation_bench.sv ----
/*
 Self-checking bench of the timed output validation block.
 Assumes the link master model and the design package are compiled.
*/
`timescale 1ns/1ps
`include "tov_defs.svh"
module timed_output_validation_bench;
	import tov_pkg::*;
	logic             clk;
	logic             arst_n;
	logic             eventPin;
	tov_link_type     linkIn;
	tov_status_type   status;
	logic [3:0][15:0] outValue;
	int               mismatches;
	int               comparisons;
	logic [31:0]      now;

	tov_link_master i_master (.clk(clk), .linkIn(linkIn));
	tov_timed_output i_dut (.clk(clk), .arst_n(arst_n),
		.eventPin(eventPin), .linkIn(linkIn), .status(status),
		.outValue(outValue));

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Time values may sit up to two microseconds off the prescaler phase
	task automatic chk_near(input logic [31:0] got, input logic [31:0] exp);
		logic [31:0] d;
		d = got - exp + 32'h2;
		comparisons++;
		if ($isunknown(got) || d > 32'h4)
		begin
			mismatches++;
			$display("mismatch at %0t: got %h near %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		#(50 * 40000);
		mismatches++;
		tally_and_finish();
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial
	begin
		arst_n = 1'b0;
		eventPin = 1'b0;
		mismatches = 0;
		comparisons = 0;
		cyc(12);
		arst_n = 1'b1;
		chk(32'(status.present), 32'h0);
		i_master.boot(32'h7FFF_FFF0);
		cyc(400);
		chk_near(status.sharedTime, 32'h8000_0004);
		repeat (3) i_master.frame(32'h1000_0000);
		cyc(2);
		chk_near(status.sharedTime, 32'h1000_0000);
		chk(32'(status.lifeCount), 32'h3);
		i_master.wr(TOV_WR_VALUE, 2'h0, 32'h0);
		cyc(2);
		chk(32'(status.led), 32'h0);
		i_master.wr(TOV_WR_VALUE, 2'h0, 32'h64);
		cyc(2);
		chk(32'(outValue[0]), 32'h64);
		chk(32'(status.led), 32'h1);
		chk(32'(status.present), 32'h0);
		i_master.wr(TOV_WR_ON, 2'h0, 32'hFF);
		cyc(2);
		chk(32'(status.onEcho), 32'h0F);
		// Channel 2 watched: 32-bit stamp, own timer, 1024 us window
		i_master.wr(TOV_WR_MODE, 2'h1, 32'h810A);
		i_master.wr(TOV_WR_VALUE, 2'h1, 32'h1F4);
		now = status.sharedTime;
		i_master.wr(TOV_WR_STAMP, 2'h1, now + 32'd100);
		cyc(2);
		chk(32'(outValue[1]), 32'h1F4);
		chk(32'(status.present), 32'h2);
		cyc(2200);
		chk(32'(outValue[1]), 32'h0);
		chk(32'(status.present), 32'h0);
		chk(32'(status.led), 32'h1);
		i_master.wr(TOV_WR_VALUE, 2'h1, 32'h258);
		cyc(2);
		chk(32'(outValue[1]), 32'h0);
		now = status.sharedTime;
		i_master.wr(TOV_WR_STAMP, 2'h1, now + 32'd500);
		cyc(2);
		chk(32'(outValue[1]), 32'h258);
		i_master.wr(TOV_WR_ON, 2'h0, 32'h0);
		cyc(2);
		chk(32'(outValue[1]), 32'h0);
		chk(32'(status.present), 32'h0);
		chk(32'(outValue[0]), 32'h64);
		chk(32'(status.onEcho), 32'h0);
		// Channel 4 on timer 2: 16-bit stamp, 1024 us window
		i_master.wr(TOV_WR_MODE, 2'h3, 32'h010A);
		i_master.wr(TOV_WR_VALUE, 2'h3, 32'h7D0);
		i_master.wr(TOV_WR_VALUE, 2'h2, 32'h3E8);
		i_master.wr(TOV_WR_ON, 2'h0, 32'h8);
		cyc(2);
		chk(32'(outValue[3]), 32'h0);
		chk(32'(outValue[2]), 32'h3E8);
		// Too far ahead for the window, so refused
		now = status.sharedTime;
		i_master.wr(TOV_WR_STAMP, 2'h1, now + 32'd5000);
		cyc(2);
		chk(32'(outValue[3]), 32'h0);
		now = status.sharedTime;
		i_master.wr(TOV_WR_STAMP, 2'h1, now + 32'd200);
		cyc(2);
		chk(32'(outValue[3]), 32'h7D0);
		chk(32'(status.present), 32'h8);
		chk(32'(status.led), 32'hD);
		cyc(4400);
		chk(32'(outValue[3]), 32'h0);
		chk(32'(status.present), 32'h0);
		chk(32'(status.led), 32'h5);
		now = status.sharedTime;
		eventPin = 1'b1;
		cyc(8);
		chk_near(status.stampTime, now);
		eventPin = 1'b0;
		cyc(2);
		tally_and_finish();
	end
endmodule

// ---- tb/tov_link_master.sv ----
/*
 Link master and controller model: cyclic writes, startup, frame time.
 Assumes the bench calls its tasks; requests change at falling edges.
*/
`timescale 1ns/1ps
`include "tov_defs.svh"
module tov_link_master
(
	input  wire logic             clk,    // Core clock
	output tov_pkg::tov_link_type linkIn  // Link requests
);
	import tov_pkg::*;
	// Shortest bus cycle the master allows itself
	localparam longint GAP_NS = 200 * `TOV_US_NS;
	longint nextOk = 0;
	initial linkIn = '0;

	// ----------------------------------------
	// Request tasks
	// ----------------------------------------
	// refTime and wrData flip, so a stale copy is never mistaken for data
	task automatic send(input tov_link_type req);
		@(negedge clk);
		linkIn = req;
		@(negedge clk);
		linkIn.frameStart = 1'b0;
		linkIn.startup = 1'b0;
		linkIn.wrEn = 1'b0;
		linkIn.refTime = ~req.refTime;
		linkIn.wrData = ~req.wrData;
	endtask

	task automatic wr(input tov_reg_type r, input logic [1:0] ch,
		input logic [31:0] d);
		tov_link_type q;
		q = '0;
		q.wrEn = 1'b1;
		q.wrReg = r;
		q.wrChan = ch;
		q.wrData = d;
		send(q);
	endtask

	task automatic boot(input logic [31:0] t);
		tov_link_type q;
		q = '0;
		q.startup = 1'b1;
		q.refTime = t;
		send(q);
	endtask

	// Reference is the mid-cycle point; network offset already applied
	task automatic frame(input logic [31:0] t);
		tov_link_type q;
		q = '0;
		q.frameStart = 1'b1;
		q.refTime = t;
		while ($time < nextOk)
			@(negedge clk);
		nextOk = $time + GAP_NS;
		send(q);
	endtask
endmodule
